//--- hw/rcis_top.sv
/*
 reset and clock initialization sequencer: captures straps on hard reset
 release, waits for pll lock, then releases internal resets; samples the
 real-time clock on the platform clock; derives the platform divider flag
 and selects the pci reference clock.
 assumes all inputs synchronous to mclk; platform clock given as an enable.
*/
// Summary of operation
// R1 - the board holds hard reset low for at least 100 us.
// R2 - the board holds soft reset low at least 3 system clocks.
// R3 - the board supplies a stable system clock 100 us before hard reset release.
// R4 - straps are set 4 clocks before and held 2 clocks after hard reset release.
// R5 - strap drivers go to high impedance within 5 clocks after release; the board model drives the inverted straps instead.
// R6 - all plls lock within 100 us, the core pll needs 255 more platform clocks.
// R7 - the rtc input is latched on the platform clock and feeds the timer counters.
// R8 - the rtc source keeps each phase longer than 2 platform clock periods.
// R9 - no minimum rtc rate; a grounded rtc just stops the counters.
// R10 - the divider flag is 0 for 333 to 400 MHz platform and 1 above 400 MHz.
// R11 - an x8 pcie link needs 333 to 400 MHz with flag 0 or 527 MHz plus with flag 1.
// R12 - asynchronous pci mode takes the pci reference clock instead of system clock.
// R13 - the board drives the straps for the whole reset.
// R14 - after core pll relock, wait 100 us plus 255 platform clocks before use; the code waits only the 255 platform clocks.
// R15 - internal reset stays asserted until every pll reports lock.
`timescale 1ns/100ps
`default_nettype none
module rcis_top
   import rcis_pkg::*;
#(
   parameter int LOCK_TIMEOUT_CYC = LOCK_MAX_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // board reset inputs
   input wire logic hard_reset_n,
   input wire logic soft_reset_n,
   // power-on straps
   input wire logic [CFG_W-1:0] cfg_straps,
   // pll status and platform clock enable
   input wire logic plat_pll_lock,
   input wire logic pci_pll_lock,
   input wire logic core_pll_lock,
   input wire logic platform_bus_clock,
   input wire logic [FREQ_W-1:0] plat_freq_mhz,
   // rtc and pci clocking
   input wire logic rtc_in,
   input wire logic pci_async_mode,
   input wire logic pci_ref_clock,
   input wire logic system_clock_in,
   // outputs
   output logic [CFG_W-1:0] cfg_latched_ff,
   output logic int_reset_n_ff,
   output logic core_clk_ok_ff,
   output logic soft_reset_req_ff,
   output logic lock_timeout_ff,
   output logic rtc_tick,
   output logic platform_ratio_div_flag_ff,
   output logic pci_clk_sel
);
   // sequencer state, counters and rtc edge history
   rcis_state_e state_ff;
   rcis_state_e nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [8:0] core_cnt_ff;
   logic [1:0] srst_cnt_ff;
   logic [1:0] hold_cnt_ff;
   logic hrst_d_ff;
   logic rtc_lat;
   logic rtc_prev_ff;
   logic all_lock;
   // all three plls report lock
   assign all_lock = plat_pll_lock & pci_pll_lock & core_pll_lock;
   // ==========================================================
   // sequencer state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         RCIS_IN_RESET: if (hard_reset_n) nxt_state = RCIS_HOLD;
         RCIS_HOLD: if (hold_cnt_ff == 2'(CFG_HOLD_CYC - 1)) nxt_state = RCIS_LOCK_WAIT;
         RCIS_LOCK_WAIT: if (plat_pll_lock & pci_pll_lock & core_pll_lock) nxt_state = RCIS_CORE_WAIT; // R15
         RCIS_CORE_WAIT: begin
            if (!core_pll_lock) nxt_state = RCIS_LOCK_WAIT;
            else if (core_cnt_ff == 9'(CORE_EXTRA_CYC)) nxt_state = RCIS_RUN; // R6
         end
         RCIS_RUN: if (!core_pll_lock) nxt_state = RCIS_CORE_WAIT; // R14
         default: nxt_state = RCIS_IN_RESET;
      endcase
      if (!hard_reset_n) nxt_state = RCIS_IN_RESET;
   end
   // state register; a core lock loss while waiting drops back to the lock wait
   always_ff @(posedge mclk) begin
      if (!rst_n) state_ff <= RCIS_IN_RESET;
      else state_ff <= nxt_state;
   end
   // ==========================================================
   // strap hold counter and capture at the start of the hold window
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hold_cnt_ff <= 2'h0;
         cfg_latched_ff <= '0;
      end else if (state_ff == RCIS_HOLD) begin
         hold_cnt_ff <= hold_cnt_ff + 2'h1;
         if (hold_cnt_ff == 2'h0) cfg_latched_ff <= cfg_straps; // R4
      end else begin
         hold_cnt_ff <= 2'h0;
      end
   end
   // ==========================================================
   // lock timeout counter over all plls
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         lock_timeout_ff <= 1'b0;
      end else if (state_ff != RCIS_LOCK_WAIT) begin
         cnt_ff <= '0;
      end else if (cnt_ff == CNT_W'(LOCK_TIMEOUT_CYC - 1)) begin
         lock_timeout_ff <= 1'b1; // R6
      end else begin
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end
   // ==========================================================
   // core pll extra platform-clock count
   always_ff @(posedge mclk) begin
      if (!rst_n) core_cnt_ff <= 9'h000;
      else if (state_ff != RCIS_CORE_WAIT) core_cnt_ff <= 9'h000;
      else if (platform_bus_clock && core_cnt_ff != 9'(CORE_EXTRA_CYC)) core_cnt_ff <= core_cnt_ff + 9'h001; // R14
   end
   // ==========================================================
   // internal reset and core clock qualifier
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         int_reset_n_ff <= 1'b0;
         core_clk_ok_ff <= 1'b0;
      end else begin
         int_reset_n_ff <= (nxt_state == RCIS_CORE_WAIT) || (nxt_state == RCIS_RUN); // R15
         core_clk_ok_ff <= (nxt_state == RCIS_RUN); // R14
      end
   end
   // ==========================================================
   // soft reset recognised after three low clocks
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         srst_cnt_ff <= 2'h0;
         soft_reset_req_ff <= 1'b0;
      end else if (soft_reset_n) begin
         srst_cnt_ff <= 2'h0;
         soft_reset_req_ff <= 1'b0;
      end else if (srst_cnt_ff != 2'(SRST_MIN_CYC - 1)) begin
         srst_cnt_ff <= srst_cnt_ff + 2'h1;
      end else begin
         soft_reset_req_ff <= 1'b1; // R2
      end
   end
   // ==========================================================
   // rtc latch on platform clock, rising edge tick to timers
   rcis_sampler u_rtc (
      .mclk(mclk),
      .rst_n(rst_n),
      .sample_en(platform_bus_clock),
      .din(rtc_in),
      .dout_ff(rtc_lat)
   ); // R7
   always_ff @(posedge mclk) begin
      if (!rst_n) rtc_prev_ff <= 1'b0;
      else rtc_prev_ff <= rtc_lat;
   end
   assign rtc_tick = rtc_lat & ~rtc_prev_ff; // R9
   // ==========================================================
   // platform divider flag from configured frequency
   always_ff @(posedge mclk) begin
      if (!rst_n) platform_ratio_div_flag_ff <= 1'b0;
      else platform_ratio_div_flag_ff <= (plat_freq_mhz > FREQ_W'(PLAT_DIV_MHZ)); // R10
   end
   // ==========================================================
   // pci reference select
   assign pci_clk_sel = pci_async_mode ? pci_ref_clock : system_clock_in; // R12
   // ==========================================================
   // assertions
   // internal reset is released only out of a fully locked lock wait
   a_int_reset_lock: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(int_reset_n_ff) |-> $past(all_lock)) else $error("internal reset released without lock"); // R15
   // core clock only after the full platform-clock count
   a_core_ok_wait: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(core_clk_ok_ff) |-> $past(core_cnt_ff) == 9'(CORE_EXTRA_CYC)) else $error("core clock used early"); // R14
   a_core_ok_reset: assert property (@(posedge mclk) disable iff (!rst_n)
      core_clk_ok_ff |-> int_reset_n_ff) else $error("core clock usable in reset"); // R15
   a_core_ok_drop: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(core_clk_ok_ff) |-> $past(!core_pll_lock || !hard_reset_n)) else $error("core clock dropped"); // R14
   // lock timeout fires at its count and then stays
   a_timeout_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      state_ff == RCIS_LOCK_WAIT && cnt_ff == CNT_W'(LOCK_TIMEOUT_CYC - 1) |=> lock_timeout_ff)
      else $error("lock timeout missed"); // R6
   a_timeout_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      lock_timeout_ff |=> lock_timeout_ff) else $error("lock timeout cleared"); // R6
   // soft reset recognised once three low clocks have been seen
   a_soft_reset_three: assert property (@(posedge mclk) disable iff (!rst_n)
      !soft_reset_n [*3] |=> soft_reset_req_ff) else $error("soft reset missed"); // R2
   a_soft_reset_early: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(soft_reset_req_ff) |-> $past(!soft_reset_n, 3)) else $error("soft reset too early"); // R2
   a_div_flag_value: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 platform_ratio_div_flag_ff == ($past(plat_freq_mhz) > FREQ_W'(PLAT_DIV_MHZ)))
      else $error("divider flag wrong"); // R10
   a_pci_sel_path: assert property (@(posedge mclk) disable iff (!rst_n)
      pci_clk_sel == (pci_async_mode ? pci_ref_clock : system_clock_in)) else $error("pci clock select wrong"); // R12
   a_rtc_tick_rise: assert property (@(posedge mclk) disable iff (!rst_n)
      rtc_tick |-> $past(platform_bus_clock && rtc_in)) else $error("rtc tick without sample"); // R7
   a_strap_capture: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(hard_reset_n) && state_ff == RCIS_IN_RESET ##1 1 |=> cfg_latched_ff == $past(cfg_straps))
      else $error("straps not captured"); // R4
   // captured straps only move inside the hold window
   a_strap_stable: assert property (@(posedge mclk) disable iff (!rst_n)
      state_ff != RCIS_HOLD |=> $stable(cfg_latched_ff)) else $error("straps changed late"); // R4
   a_hard_reset_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !hard_reset_n |=> !int_reset_n_ff) else $error("internal reset not held"); // R15
   // main scenarios reached
   c_run: cover property (@(posedge mclk) disable iff (!rst_n) $rose(core_clk_ok_ff));
   c_relock: cover property (@(posedge mclk) disable iff (!rst_n) $fell(core_clk_ok_ff) && hard_reset_n);
   c_timeout: cover property (@(posedge mclk) disable iff (!rst_n) $rose(lock_timeout_ff));
   c_rtc: cover property (@(posedge mclk) disable iff (!rst_n) rtc_tick);
   c_soft: cover property (@(posedge mclk) disable iff (!rst_n) $rose(soft_reset_req_ff));
endmodule
`default_nettype wire

//--- pkg/rcis_pkg.sv
/*
 constants for the reset and clock initialization sequencer.
 assumes a single 40 MHz mclk; the microsecond times are converted to mclk cycles here, while CORE_EXTRA_CYC counts platform clocks.
*/
`default_nettype none
package rcis_pkg;
   // ==========================================================
   // clock rate
   localparam int CLK_MHZ = 40;
   localparam int CLK_NS = 25;
   // ==========================================================
   // reset and strap timing
   localparam int HRST_MIN_US = 100;
   localparam int HRST_MIN_CYC = HRST_MIN_US * CLK_MHZ;
   localparam int SRST_MIN_CYC = 3;
   localparam int CFG_SETUP_CYC = 4;
   localparam int CFG_HOLD_CYC = 2;
   localparam int CFG_RELEASE_CYC = 5;
   // ==========================================================
   // pll lock timing
   localparam int LOCK_MAX_US = 100;
   localparam int LOCK_MAX_CYC = LOCK_MAX_US * CLK_MHZ;
   localparam int CORE_EXTRA_CYC = 255;
   localparam int CNT_W = 13;
   // ==========================================================
   // platform frequency thresholds in MHz
   localparam int PLAT_LOW_MHZ = 333;
   localparam int PLAT_DIV_MHZ = 400;
   localparam int PLAT_X8_MHZ = 527;
   localparam int FREQ_W = 11;
   // ==========================================================
   // strap width
   localparam int CFG_W = 8;
   typedef enum logic [2:0] {
      RCIS_IN_RESET, RCIS_HOLD, RCIS_LOCK_WAIT, RCIS_CORE_WAIT, RCIS_RUN
   } rcis_state_e;
endpackage
`default_nettype wire

//--- hw/rcis_sampler.sv
/*
 one-stage level latch clocked by a qualifying enable.
 assumes the input is synchronous to mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module rcis_sampler
   import rcis_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // sample enable and data
   input wire logic sample_en,
   input wire logic din,
   output logic dout_ff
);
   // ==========================================================
   // latch the level on each enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dout_ff <= 1'b0;
      end else if (sample_en) begin
         dout_ff <= din;
      end
   end
endmodule
`default_nettype wire

//--- verification/rcis_board_model.sv
/*
 board reset and strap controller model: on request pulses hard or soft reset.
 assumes requests are single-cycle pulses on mclk driven by non-blocking assignment.
*/
`timescale 1ns/100ps
`default_nettype none
module rcis_board_model
   import rcis_pkg::*;
#(
   parameter int HOLD_CYC = HRST_MIN_CYC
)
(
   // clock
   input wire logic mclk,
   // requests
   input wire logic hard_req,
   input wire logic soft_req,
   input wire logic [CFG_W-1:0] strap_val,
   // board pins
   output logic hard_reset_n,
   output logic soft_reset_n,
   output logic [CFG_W-1:0] cfg_straps
);
   // ==========================================================
   // power-on state: in reset, straps driven, clock stable from time zero
   initial begin
      hard_reset_n = 1'b0;
      soft_reset_n = 1'b1;
      cfg_straps = strap_val;
   end
   // one reset sequence per request
   always begin
      @(posedge mclk);
      if (hard_req) begin
         hard_reset_n <= 1'b0;
         cfg_straps <= strap_val;
         repeat (HOLD_CYC) @(posedge mclk);
         hard_reset_n <= 1'b1;
         repeat (CFG_RELEASE_CYC) @(posedge mclk);
         cfg_straps <= ~strap_val; // released straps no longer show the value
      end else if (soft_req) begin
         soft_reset_n <= 1'b0;
         repeat (SRST_MIN_CYC) @(posedge mclk);
         soft_reset_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- verification/testbench.sv
/*
 self-checking bench for the reset and clock initialization sequencer.
 assumes the board model above and a 40 MHz mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rcis_pkg::*;
   localparam int LT = 20;
   localparam logic [CFG_W-1:0] STRAP = 8'hA5;
   logic mclk = 0, rst_n = 0, hard_req = 0, soft_req = 0, hard_reset_n, soft_reset_n;
   logic plat_lk = 0, pci_lk = 0, core_lk = 0, pbc = 0, rtc_in = 0, async_md = 0, pref = 1, sysck = 0;
   logic [CFG_W-1:0] cfg_straps, cfg_latched_ff;
   logic [FREQ_W-1:0] freq = 11'h14D;
   logic int_reset_n_ff, core_clk_ok_ff, soft_reset_req_ff, lock_timeout_ff, rtc_tick, div_ff, pci_clk_sel;
   int bad_count = 0, samples_checked = 0, n;
   // ==========================================================
   // clock and platform clock enable
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) pbc <= ~pbc;
   rcis_board_model board (.mclk(mclk), .hard_req(hard_req), .soft_req(soft_req), .strap_val(STRAP),
      .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n), .cfg_straps(cfg_straps));
   rcis_top #(.LOCK_TIMEOUT_CYC(LT)) dut (.mclk(mclk), .rst_n(rst_n), .hard_reset_n(hard_reset_n),
      .soft_reset_n(soft_reset_n), .cfg_straps(cfg_straps), .plat_pll_lock(plat_lk), .pci_pll_lock(pci_lk),
      .core_pll_lock(core_lk), .platform_bus_clock(pbc), .plat_freq_mhz(freq), .rtc_in(rtc_in),
      .pci_async_mode(async_md), .pci_ref_clock(pref), .system_clock_in(sysck),
      .cfg_latched_ff(cfg_latched_ff), .int_reset_n_ff(int_reset_n_ff), .core_clk_ok_ff(core_clk_ok_ff),
      .soft_reset_req_ff(soft_reset_req_ff), .lock_timeout_ff(lock_timeout_ff), .rtc_tick(rtc_tick),
      .platform_ratio_div_flag_ff(div_ff), .pci_clk_sel(pci_clk_sel));
   // ==========================================================
   // comparison, verdict and bounded waits
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task conclude();
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function logic sel(input int w);
      case (w)
         0: sel = int_reset_n_ff;
         1: sel = core_clk_ok_ff;
         2: sel = lock_timeout_ff;
         3: sel = soft_reset_req_ff;
         default: sel = hard_reset_n;
      endcase
   endfunction
   task wait_for(input int w, input int lim, output int k);
      k = 0;
      while (sel(w) !== 1'b1) begin
         @(posedge mclk);
         #1;
         k++;
         if (k > lim) begin
            bad_count++;
            conclude();
         end
      end
   endtask
   task hard_cycle();
      @(posedge mclk) hard_req <= 1;
      @(posedge mclk) hard_req <= 0;
      #1;
      wait_for(4, HRST_MIN_CYC + 10, n);
   endtask
   // ==========================================================
   // scenarios
   task t_power_up();
      hard_cycle();
      repeat (10) @(posedge mclk);
      #1;
      check(int_reset_n_ff, 0);
      check(cfg_latched_ff, STRAP);
      @(posedge mclk) {plat_lk, pci_lk, core_lk} <= 3'h7;
      #1;
      wait_for(0, 4, n);
      wait_for(1, 600, n);
      check(n >= 505 && n <= 515, 1);
   endtask
   task t_relock();
      @(posedge mclk) core_lk <= 0;
      repeat (3) @(posedge mclk);
      #1;
      // a lasting core lock loss falls back to the lock wait with internal reset asserted
      check({core_clk_ok_ff, int_reset_n_ff}, 2'h0);
      @(posedge mclk) core_lk <= 1;
      #1;
      wait_for(1, 600, n);
      check(n >= 505 && n <= 515, 1);
   endtask
   task t_soft_rtc();
      @(posedge mclk) soft_req <= 1;
      @(posedge mclk) soft_req <= 0;
      #1;
      wait_for(3, 10, n);
      check(n >= SRST_MIN_CYC, 1);
      n = 0;
      @(posedge mclk) rtc_in <= 1;
      repeat (12) begin
         @(posedge mclk);
         #1;
         n += (rtc_tick === 1'b1);
      end
      check(n, 1);
      n = 0;
      @(posedge mclk) rtc_in <= 0;
      repeat (300) begin
         @(posedge mclk);
         #1;
         n += (rtc_tick === 1'b1);
      end
      check(n, 0);
   endtask
   task t_freq_pci();
      int f[4] = '{333, 400, 401, 527};
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) freq <= f[i][FREQ_W-1:0];
         repeat (3) @(posedge mclk);
         #1;
         check(div_ff, i > 1);
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge mclk) async_md <= m[0];
         #1;
         check(pci_clk_sel, m[0]);
      end
   endtask
   task t_timeout();
      @(posedge mclk) {plat_lk, pci_lk, core_lk} <= 3'h0;
      hard_cycle();
      wait_for(2, LT + 12, n);
      check(n >= LT && n <= LT + 6, 1);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1;
      t_power_up();
      t_relock();
      t_soft_rtc();
      t_freq_pci();
      t_timeout();
      conclude();
   end
endmodule
`default_nettype wire
